// *** design/fbm_host.sv ***
`timescale 1ns/1ps
module fbm_host #(
  parameter int RP_CYCLES    = fbm_pkg::RP_CYC,
  parameter int READY_CYCLES = fbm_pkg::READY_CYC,
  parameter bit WORD_MODE    = 1'b1
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_ce,
  input  wire fbm_pkg::fbm_req_s         i_req,
  input  wire logic                      i_req_valid,
  output logic                           o_req_ready,
  output logic [fbm_pkg::DATA_W-1:0]     o_rd_data,
  output logic                           o_rd_valid,
  output logic                           o_busy_seen,
  output fbm_pkg::fbm_ctl_s              o_ctl,
  output logic [fbm_pkg::ADDR_W-1:0]     o_addr,
  output logic                           o_byte_n,
  output logic [fbm_pkg::DATA_W-1:0]     o_dq,
  output logic [fbm_pkg::DATA_W-1:0]     o_dq_oe,
  input  wire logic [fbm_pkg::DATA_W-1:0] i_dq,
  input  wire logic                      i_ready_busy_n
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [fbm_pkg::DATA_W-1:0] dq_s1_ff, dq_s2_ff;
  logic                       rb_s1_ff, rb_s2_ff;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
      rb_s1_ff <= 1'b0;
      rb_s2_ff <= 1'b0;
    end else if (i_ce) begin
      dq_s1_ff <= i_dq;
      dq_s2_ff <= dq_s1_ff;
      rb_s1_ff <= i_ready_busy_n;
      rb_s2_ff <= rb_s1_ff;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  fbm_pkg::fbm_state_e        state_ff;
  logic [fbm_pkg::CNT_W-1:0]  cnt_ff;
  logic [1:0]                 step_ff;
  fbm_pkg::fbm_req_s          req_ff;
  logic [fbm_pkg::ADDR_W-1:0] waddr;
  logic [fbm_pkg::DATA_W-1:0] wdata;

  function automatic logic [fbm_pkg::CNT_W-1:0] cyc(input int n);
    cyc = fbm_pkg::CNT_W'(n - 1);
  endfunction

  // unlock prefix for a full program; bypass needs only command plus data
  always_comb begin
    waddr = req_ff.addr[fbm_pkg::ADDR_W:1];
    wdata = req_ff.data;
    if (req_ff.op == fbm_pkg::OP_PROG) begin
      unique case (step_ff)
        2'h0: begin
          waddr = fbm_pkg::ADDR_W'(fbm_pkg::UNLOCK_A1);
          wdata = req_ff.bypass ? fbm_pkg::CMD_PROG : fbm_pkg::UNLOCK_D1;
        end
        2'h1: begin
          waddr = fbm_pkg::ADDR_W'(fbm_pkg::UNLOCK_A2);
          wdata = fbm_pkg::UNLOCK_D2;
        end
        2'h2: begin
          waddr = fbm_pkg::ADDR_W'(fbm_pkg::UNLOCK_A1);
          wdata = fbm_pkg::CMD_PROG;
        end
        default: ;
      endcase
    end
  end

  // bypass jumps from step 0 straight to the data write
  logic last_step;
  assign last_step = (req_ff.op != fbm_pkg::OP_PROG) || (step_ff == 2'h3);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= fbm_pkg::ST_RST;
      cnt_ff   <= '0;
      step_ff  <= '0;
      req_ff   <= '0;
    end else if (i_ce) begin
      unique case (state_ff)
        // power-up holds the flash in reset so it starts in array read
        fbm_pkg::ST_RST: begin
          if (cnt_ff == cyc(RP_CYCLES)) begin
            cnt_ff   <= '0;
            state_ff <= fbm_pkg::ST_RCV;
          end else cnt_ff <= cnt_ff + 1'b1;
        end
        fbm_pkg::ST_RCV: begin
          if (cnt_ff == cyc(fbm_pkg::RH_CYC)) begin
            cnt_ff   <= '0;
            state_ff <= fbm_pkg::ST_RDY;
          end else cnt_ff <= cnt_ff + 1'b1;
        end
        // wait for the flash to finish its internal reset before commands
        fbm_pkg::ST_RDY: begin
          if (rb_s2_ff || cnt_ff == cyc(READY_CYCLES)) begin
            cnt_ff   <= '0;
            state_ff <= fbm_pkg::ST_IDLE;
          end else cnt_ff <= cnt_ff + 1'b1;
        end
        fbm_pkg::ST_IDLE: begin
          if (i_req_valid) begin
            req_ff  <= i_req;
            step_ff <= '0;
            cnt_ff  <= '0;
            unique case (i_req.op)
              fbm_pkg::OP_READ:  state_ff <= fbm_pkg::ST_RD;
              fbm_pkg::OP_RESET: state_ff <= fbm_pkg::ST_RST;
              default:           state_ff <= fbm_pkg::ST_WLO;
            endcase
          end
        end
        // address access bound covers wake from standby and new address
        fbm_pkg::ST_RD: begin
          if (cnt_ff == cyc(fbm_pkg::ACC_CYC + 2)) begin
            cnt_ff   <= '0;
            state_ff <= fbm_pkg::ST_IDLE;
          end else cnt_ff <= cnt_ff + 1'b1;
        end
        fbm_pkg::ST_WLO: begin
          if (cnt_ff == cyc(fbm_pkg::WP_CYC)) begin
            cnt_ff   <= '0;
            state_ff <= fbm_pkg::ST_WHI;
          end else cnt_ff <= cnt_ff + 1'b1;
        end
        fbm_pkg::ST_WHI: begin
          if (cnt_ff == cyc(fbm_pkg::WH_CYC)) begin
            cnt_ff <= '0;
            if (last_step) state_ff <= fbm_pkg::ST_IDLE;
            else begin
              step_ff  <= (req_ff.bypass && step_ff == 2'h0) ? 2'h3 : step_ff + 2'h1;
              state_ff <= fbm_pkg::ST_WLO;
            end
          end else cnt_ff <= cnt_ff + 1'b1;
        end
        default: state_ff <= fbm_pkg::ST_RST;
      endcase
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  logic byte_lane;
  assign byte_lane = !WORD_MODE;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ctl    <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0};
      o_addr   <= '0;
      o_dq     <= '0;
      o_dq_oe  <= '0;
      // width pin starts at its configured level so no false width change follows reset
      o_byte_n <= WORD_MODE;
    end else if (i_ce) begin
      o_byte_n    <= WORD_MODE;
      o_ctl.rst_n <= (state_ff != fbm_pkg::ST_RST);
      // deselect between cycles gives standby; any running operation carries on
      o_ctl.ce_n  <= !(state_ff == fbm_pkg::ST_RD || state_ff == fbm_pkg::ST_WLO
                       || state_ff == fbm_pkg::ST_WHI);
      o_ctl.oe_n  <= (state_ff != fbm_pkg::ST_RD);
      o_ctl.we_n  <= (state_ff != fbm_pkg::ST_WLO);
      if (state_ff == fbm_pkg::ST_RD) o_addr <= req_ff.addr[fbm_pkg::ADDR_W:1];
      else if (state_ff == fbm_pkg::ST_WLO) o_addr <= waddr;
      // drive data while writing, and in byte mode dq15 with the low address bit during reads; the rest floated while the flash may drive
      if (state_ff == fbm_pkg::ST_WLO || state_ff == fbm_pkg::ST_WHI) begin
        o_dq    <= byte_lane ? {req_ff.addr[0], 7'h00, wdata[7:0]} : wdata;
        o_dq_oe <= byte_lane ? 16'h80FF : 16'hFFFF;
      end else if (state_ff == fbm_pkg::ST_RD && byte_lane) begin
        o_dq    <= {req_ff.addr[0], 15'h0000};
        o_dq_oe <= 16'h8000;
      end else begin
        o_dq    <= '0;
        o_dq_oe <= '0;
      end
    end
  end

  // ----------------------------------------
  // user side
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_req_ready <= 1'b0;
      o_rd_valid  <= 1'b0;
      o_rd_data   <= '0;
      o_busy_seen <= 1'b0;
    end else if (i_ce) begin
      o_req_ready <= (state_ff == fbm_pkg::ST_IDLE) && !i_req_valid;
      o_busy_seen <= !rb_s2_ff;
      o_rd_valid  <= 1'b0;
      if (state_ff == fbm_pkg::ST_RD && cnt_ff == cyc(fbm_pkg::ACC_CYC + 2)) begin
        o_rd_valid <= 1'b1;
        o_rd_data  <= byte_lane ? {8'h00, dq_s2_ff[7:0]} : dq_s2_ff;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_read_ctl: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_ctl.oe_n |-> (!o_ctl.ce_n && o_ctl.we_n && o_ctl.rst_n)) else $error("read pins bad");
  a_write_ctl: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_ctl.we_n |-> (!o_ctl.ce_n && o_ctl.oe_n && (&o_dq_oe[7:0]))) else $error("write pins bad");
  a_no_contend: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_ctl.oe_n |-> (o_dq_oe[14:0] == 15'h0000)) else $error("bus contention");
  a_reset_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(o_ctl.rst_n) && i_ce |-> !o_ctl.rst_n[*2]) else $error("reset pulse short");
  a_rcv_gap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(o_ctl.rst_n) |-> o_ctl.oe_n[*2]) else $error("read too soon after reset");
  a_rd_valid: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_rd_valid |-> $past(!o_ctl.oe_n, 2)) else $error("read data without access");
  a_ce_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_ff == fbm_pkg::ST_IDLE && i_ce) |=> o_ctl.ce_n) else $error("no standby");
  a_byte_pin: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_ce) |-> o_byte_n == WORD_MODE) else $error("width pin wrong");
  c_read: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_rd_valid);
  c_write: cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(o_ctl.we_n));
  c_reset: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(o_ctl.rst_n));
endmodule // fbm_host

// *** design/fbm_pkg.sv ***
// Overview of operation
// - read: chip select and output enable low, write enable high; flash drives data.
// - write: write enable and chip select low, output enable high; flash latches.
// - unlock bypass program takes two write cycles instead of four.
// - host reads no earlier than recovery time after reset returns high.
// - host does not restart a program or erase interrupted by hardware reset; it is abandoned.
package fbm_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BANK_MSB = 20;
  localparam int BANK_LSB = 19;
  localparam int CLK_PS = 5000;
  localparam int ADDRESS_ACCESS_TIME_PS = 70000;
  localparam int T_WP_PS = 35000;
  localparam int T_WH_PS = 20000;
  localparam int T_RP_PS = 500000;
  localparam int T_RH_PS = 50000;
  localparam int T_READY_PS = 20000000;
  localparam int ACC_CYC = (ADDRESS_ACCESS_TIME_PS + CLK_PS - 1) / CLK_PS;
  localparam int WP_CYC = (T_WP_PS + CLK_PS - 1) / CLK_PS;
  localparam int WH_CYC = (T_WH_PS + CLK_PS - 1) / CLK_PS;
  localparam int RP_CYC = (T_RP_PS + CLK_PS - 1) / CLK_PS;
  localparam int RH_CYC = (T_RH_PS + CLK_PS - 1) / CLK_PS;
  localparam int READY_CYC = (T_READY_PS + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 16;
  localparam logic [15:0] UNLOCK_A1 = 16'h0555;
  localparam logic [15:0] UNLOCK_A2 = 16'h02AA;
  localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
  localparam logic [15:0] UNLOCK_D2 = 16'h0055;
  localparam logic [15:0] CMD_PROG = 16'h00A0;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PROG = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h3;
  typedef struct packed {
    logic [1:0]        op;
    logic              bypass;
    logic [ADDR_W:0]   addr;
    logic [DATA_W-1:0] data;
  } fbm_req_s;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
  } fbm_ctl_s;
  typedef enum logic [6:0] {
    ST_RST  = 7'h01,
    ST_RCV  = 7'h02,
    ST_IDLE = 7'h04,
    ST_RD   = 7'h08,
    ST_WLO  = 7'h10,
    ST_WHI  = 7'h20,
    ST_RDY  = 7'h40
  } fbm_state_e;
endpackage

// *** test/fbm_flash_model.sv ***
`timescale 1ns/1ps
// ----------
// flash device model
// ----------
module fbm_flash_model (
  input  wire fbm_pkg::fbm_ctl_s i_ctl,
  input  wire logic [20:0]       i_addr,
  input  wire logic [15:0]       i_dq,
  output logic [15:0]            o_dq,
  output logic                   o_ready_busy_n
);
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0000;
  logic [15:0] pd;
  logic [3:0]  pa;
  logic [1:0]  st = 2'h0;
  logic        byp = 1'b0;
  logic        abort = 1'b0;
  int          left = 0;
  wire logic   rd = !i_ctl.ce_n && !i_ctl.oe_n && i_ctl.we_n && i_ctl.rst_n;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hC300 | 16'(i);
    o_ready_busy_n = 1'b1;
  end
  // any bank reads while a program runs; data stays latched while the address rests
  always @* if (rd) last = mem[i_addr[3:0]];
  // released bus shows the inverse so a late sample cannot pass by luck
  assign #60 o_dq = rd ? last : ~last;
  always @(posedge i_ctl.we_n) if (!i_ctl.ce_n && i_ctl.rst_n) begin
    case (st)
      2'h0: if (byp && i_dq == 16'h00A0) st = 2'h3;
        else if (i_addr == 21'h000555 && i_dq == 16'h00AA) st = 2'h1;
      2'h1: st = (i_addr == 21'h0002AA && i_dq == 16'h0055) ? 2'h2 : 2'h0;
      2'h2: begin
        byp = byp | (i_dq == 16'h0020);
        st = (i_dq == 16'h00A0) ? 2'h3 : 2'h0;
      end
      default: begin
        pa = i_addr[3:0];
        pd = i_dq;
        abort = 1'b0;
        left = 40;
        o_ready_busy_n = 1'b0;
        st = 2'h0;
      end
    endcase
  end
  always @(negedge i_ctl.rst_n) begin
    st = 2'h0;
    byp = 1'b0;
    abort = !o_ready_busy_n;
    if (abort) left = 20;
  end
  always #5 if (left > 0) begin
    left = left - 1;
    if (left == 0) begin
      if (!abort) mem[pa] = pd;
      o_ready_busy_n = 1'b1;
    end
  end
endmodule // fbm_flash_model

// *** test/fbm_host_test.sv ***
`timescale 1ns/1ps
// ----------
// host front end bench
// ----------
module fbm_host_test;
  typedef struct { logic [1:0] op; logic [20:0] a; logic [15:0] d; int wes; } fbm_row_s;
  logic              i_clock = 1'b0;
  logic              i_rst_n = 1'b0;
  logic              i_ce = 1'b1;
  logic              i_req_valid = 1'b0;
  fbm_pkg::fbm_req_s i_req = '0;
  logic [15:0]       o_rd_data, o_dq, o_dq_oe, fl_dq, got;
  logic              o_req_ready, o_rd_valid, o_busy_seen, o_byte_n, i_ready_busy_n;
  fbm_pkg::fbm_ctl_s o_ctl;
  logic [20:0]       o_addr;
  int                err_total = 0, tests_run = 0, cyc = 0, wes = 0;
  logic [20:0]       ca [0:3] = '{21'h000555, 21'h0002AA, 21'h000555, 21'h000004};
  logic [15:0]       cd [0:3] = '{16'h00AA, 16'h0055, 16'h00A0, 16'h5A5A};
  fbm_row_s          rows [0:7] = '{'{2'h0, 21'h1, 16'hC301, 0}, '{2'h0, 21'hF, 16'hC30F, 0},
    '{2'h2, 21'h2, 16'h1234, 4}, '{2'h0, 21'h2, 16'h1234, 0}, '{2'h1, 21'h9, 16'h00F0, 1},
    '{2'h0, 21'h9, 16'hC309, 0}, '{2'h2, 21'h3, 16'hABCD, 4}, '{2'h0, 21'h3, 16'hABCD, 0}};
  wire logic [15:0]  bus = (o_dq & o_dq_oe) | (fl_dq & ~o_dq_oe);
  fbm_host #(.RP_CYCLES(3), .READY_CYCLES(40), .WORD_MODE(1'b1)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_req(i_req), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_busy_seen(o_busy_seen), .o_ctl(o_ctl), .o_addr(o_addr), .o_byte_n(o_byte_n),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dq(bus), .i_ready_busy_n(i_ready_busy_n));
  fbm_flash_model flash (.i_ctl(o_ctl), .i_addr(o_addr), .i_dq(bus), .o_dq(fl_dq), .o_ready_busy_n(i_ready_busy_n));
  always #2.5 i_clock = ~i_clock;
  always @(negedge o_ctl.we_n) wes++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // both sides driving while the flash outputs would be contention
  always @(posedge i_clock) if (i_rst_n && !o_ctl.oe_n && o_dq_oe !== 16'h0000) check(o_dq_oe, 16'h0000);
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic run(input logic [1:0] op, input logic byp, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 300) begin @(negedge i_clock); n++; end
    if (n >= 300) err_total++;
    wes = 0;
    i_req = {op, byp, a, 1'b0, d};
    i_req_valid = 1'b1;
    @(negedge i_clock);
    i_req_valid = 1'b0;
    @(negedge i_clock);
    n = 0;
    while ((op == 2'h0 ? o_rd_valid : o_req_ready) !== 1'b1 && n < 300) begin @(negedge i_clock); n++; end
    if (n >= 300) err_total++;
    got = o_rd_data;
    // pins follow the state one cycle late, so let them settle back to idle
    @(negedge i_clock);
    if (op == 2'h2) begin
      check(16'(o_busy_seen), 16'h0001);
      n = 0;
      while (o_busy_seen !== 1'b0 && n < 300) begin @(negedge i_clock); n++; end
      if (n >= 300) err_total++;
    end
  endtask
  initial begin
    repeat (2) @(negedge i_clock);
    check(16'(o_ctl), 16'h000E);
    check(o_dq_oe, 16'h0000);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    check(16'(o_req_ready), 16'h0000);
    check(16'(o_byte_n), 16'h0001);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      run(rows[k].op, 1'b0, rows[k].a, rows[k].d);
      if (rows[k].op == 2'h0) check(got, rows[k].d);
      else check(16'(wes), 16'(rows[k].wes));
      check(16'(o_ctl), 16'h000F);
    end
    $display("row test done");
    for (int i = 0; i < 4; i++) run(2'h1, 1'b0, ca[i], cd[i]);
    run(2'h3, 1'b0, 21'h0, 16'h0000);
    check(16'(o_busy_seen), 16'h0000);
    run(2'h0, 1'b0, 21'h4, 16'h0000);
    check(got, 16'hC304);
    $display("abort test done");
    cd[2] = 16'h0020;
    for (int i = 0; i < 3; i++) run(2'h1, 1'b0, ca[i], cd[i]);
    run(2'h2, 1'b1, 21'h5, 16'h7E81);
    check(16'(wes), 16'h0002);
    run(2'h0, 1'b0, 21'h5, 16'h0000);
    check(got, 16'h7E81);
    $display("bypass test done");
    summarize();
  end
endmodule // fbm_host_test
